// ==== egq_consts.vh ====
/*
 * Constants of the queue 3 egress rate limiter: register offsets, field
 * layout, reset values, rate codes and shaper timing.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef EGQ_CONSTS_VH
`define EGQ_CONSTS_VH

// Queue 3 egress rate registers, one per port
`define EGQ_Q3_RATE_P1_OFF   8'hBE
`define EGQ_Q3_RATE_P2_OFF   8'hCE
`define EGQ_Q3_RATE_P3_OFF   8'hDE
`define EGQ_Q3_RATE_P4_OFF   8'hEE
`define EGQ_Q3_RATE_P5_OFF   8'hFE
// Port stride between the per-port register groups
`define EGQ_PORT_STRIDE      8'h10

// Field layout and reset value
`define EGQ_RATE_MSB         6
`define EGQ_RATE_LSB         0
`define EGQ_RATE_RST         7'h00

// Rate codes
`define EGQ_CODE_DEFAULT     7'h00
`define EGQ_CODE_FAST_FULL   7'h64
`define EGQ_CODE_SLOW_FULL   7'h0A
`define EGQ_CODE_SUB_FIRST   7'h65
`define EGQ_CODE_SUB_LAST    7'h73
`define EGQ_SUB_STEP_KBPS    17'h00040
`define EGQ_KBPS_PER_MBPS    17'h003E8

// Shaper timing: credit is refilled once per tick
`define EGQ_CLK_NS           5
`define EGQ_TICK_NS          1000
`define EGQ_TICK_CYC         (`EGQ_TICK_NS / `EGQ_CLK_NS)

// Credit is counted in millibits; one byte costs 8000 of them
`define EGQ_MBIT_PER_BYTE    25'h0001F40
`define EGQ_BUCKET_MAX       25'h0F42400

`endif

// ==== egq_port_shaper.v ====
/*
 * Token-bucket shaper for one port's queue 3.
 * Assumes rate and unlimited come from the rate decode in the same clock
 * domain, and that tick is a one-cycle pulse once per microsecond.
 */
`timescale 1ns/1ps
`include "egq_consts.vh"

module egq_port_shaper (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Decoded rate
    input  wire [16:0] rate_kbps,
    input  wire        unlimited,
    // Refill tick, frame cost and debit
    input  wire        tick,
    input  wire [10:0] frame_len,
    input  wire        debit,
    // Credit state
    output wire        send_ok
);

    reg  [24:0] credit_r;
    reg  [24:0] credit_nxt;
    wire [24:0] cost;
    wire [25:0] refill;

    // One microsecond at N kbit/s is N millibits, so the rate adds directly
    assign cost    = frame_len * `EGQ_MBIT_PER_BYTE;
    assign refill  = {1'b0, credit_r} + {9'h000, rate_kbps};
    assign send_ok = unlimited | (credit_r >= cost);

    // Refill, cap at one largest frame so idle time cannot bank a burst
    always @* begin
        credit_nxt = credit_r;
        if (unlimited) begin
            credit_nxt = `EGQ_BUCKET_MAX;
        end else begin
            if (tick) begin
                if (refill > {1'b0, `EGQ_BUCKET_MAX})
                    credit_nxt = `EGQ_BUCKET_MAX;
                else
                    credit_nxt = refill[24:0];
            end
            if (debit) begin
                if (credit_nxt >= cost)
                    credit_nxt = credit_nxt - cost;
                else
                    credit_nxt = 25'h0000000;
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst)
            credit_r <= 25'h0000000;
        else
            credit_r <= credit_nxt;
    end

endmodule

// ==== egq_rate_limiter.v ====
/*
 * Queue 3 egress rate limiter for a five-port switch: per-port rate
 * code registers, rate decode for both link speeds, queue 3 shaping and
 * strict priority selection with ratio pacing of the lower queues.
 * Assumes the register port, link speed, queue mode and queue requests
 * all come from switch core logic on the same clock.
 */
`timescale 1ns/1ps
`include "egq_consts.vh"

// Overview of operation
// - Each port has a 7-bit queue 3 rate code in bits 6..0, reset zero.
// - In four-queue mode, queue 3 traffic leaves each port at the rate its code selects.
// - In four-queue mode queue 3 is the highest priority queue.
// - Queue 3 gets the exact coded rate; lower queues follow ratio settings only while queue 3 is limited.
// - At 100 Mbit, codes 1 to 99 limit to that many Mbit/s.
// - At 100 Mbit, code 0 or 100 means full rate, no limiting.
// - At 10 Mbit, codes 1 to 9 limit to that many Mbit/s.
// - At 10 Mbit, code 0 or 10 means full 10 Mbit rate.
// - Codes 101 to 115 give 64 to 960 kbit/s in 64 kbit steps.
// - In four-queue mode queue 0 is lowest; priority rises with number.
module egq_rate_limiter #(
    parameter NPORT    = 5,
    parameter RATIO_W  = 8
) (
    // Clock and reset
    input  wire                   clk,
    input  wire                   rst,
    // Register access port
    input  wire [7:0]             reg_addr,
    input  wire                   reg_wr,
    input  wire [7:0]             reg_wdata,
    input  wire                   reg_rd,
    output reg  [7:0]             reg_rdata,
    // Per-port link state
    input  wire [NPORT-1:0]       fast_link_speed,
    input  wire [NPORT-1:0]       four_queue_mode,
    // Per-port queue requests, four bits per port, bit n is queue n
    input  wire [4*NPORT-1:0]     q_pend,
    input  wire [11*NPORT-1:0]    q3_len,
    input  wire [RATIO_W*NPORT-1:0] lo_ratio,
    // Per-port grants, one-cycle one-hot pulse per port
    output reg  [4*NPORT-1:0]     tx_grant
);

    // Rate decode: returns {unlimited, rate in kbit/s}.
    // The sub-megabit band is checked first because it is the same at both
    // link speeds. Anything not listed runs at the full link rate, so a bad
    // code never stalls queue 3. The trade is that a mistyped code silently
    // removes the limit instead of blocking the port.
    function [17:0] egq_decode;
        input [6:0] code;
        input       fast;
        reg   [16:0] mbps;
        reg   [16:0] sub;
        begin
            mbps = {10'h000, code};
            sub  = {10'h000, code - `EGQ_CODE_SUB_FIRST};
            if (code >= `EGQ_CODE_SUB_FIRST && code <= `EGQ_CODE_SUB_LAST)
                egq_decode = {1'b0, (sub + 17'h00001) * `EGQ_SUB_STEP_KBPS};
            else if (code == `EGQ_CODE_DEFAULT)
                egq_decode = {1'b1, 17'h00000};
            else if (fast && code < `EGQ_CODE_FAST_FULL)
                egq_decode = {1'b0, mbps * `EGQ_KBPS_PER_MBPS};
            else if (!fast && code < `EGQ_CODE_SLOW_FULL)
                egq_decode = {1'b0, mbps * `EGQ_KBPS_PER_MBPS};
            else
                egq_decode = {1'b1, 17'h00000};
        end
    endfunction

    // Shared microsecond tick for all shapers.
    // One counter serves every port, so all buckets refill on the same edge.
    // This keeps the refill adder narrow: the rate in kbit/s is exactly the
    // millibits earned per microsecond.
    reg  [7:0] tick_cnt_r;
    reg        tick_r;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= 8'h00;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == `EGQ_TICK_CYC - 1) begin
            tick_cnt_r <= 8'h00;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 8'h01;
            tick_r     <= 1'b0;
        end
    end

    // Rate code storage, flattened seven bits per port
    reg  [7*NPORT-1:0] rate_code_r;
    reg  [7:0]         rdata_nxt;
    wire [4*NPORT-1:0] grant_all;
    integer            k;
    integer            j;

    // Writes land only in bits 6..0 of the addressed port's register.
    // One process owns the whole vector so that every bit has one driver;
    // bit 7 is reserved and simply not stored.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_code_r <= {NPORT{`EGQ_RATE_RST}};
        end else begin
            for (j = 0; j < NPORT; j = j + 1) begin
                if (reg_wr && reg_addr == `EGQ_Q3_RATE_P1_OFF + j * `EGQ_PORT_STRIDE)
                    rate_code_r[7*j +: 7] <= reg_wdata[`EGQ_RATE_MSB:`EGQ_RATE_LSB];
            end
        end
    end

    // Read mux: only the low seven bits exist, bit 7 reads zero.
    // Unmapped addresses fall through to zero rather than to the last
    // register, so software never mistakes a wrong address for a value.
    always @* begin
        rdata_nxt = 8'h00;
        for (k = 0; k < NPORT; k = k + 1) begin
            if (reg_addr == `EGQ_Q3_RATE_P1_OFF + k * `EGQ_PORT_STRIDE)
                rdata_nxt = {1'b0, rate_code_r[7*k +: 7]};
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
    end

    // Per-port logic: decode, shaper, arbiter and lower-queue budget.
    // Each port is independent apart from the shared tick.
    genvar p;
    generate
        for (p = 0; p < NPORT; p = p + 1) begin : g_port
            wire [17:0]        dec;
            wire               unlim;
            wire               q3_ok;
            wire [3:0]         pend;
            wire               lo_ok;
            wire               idle;
            reg  [3:0]         grant_nxt;
            reg  [RATIO_W-1:0] lo_budget_r;

            assign dec    = egq_decode(rate_code_r[7*p +: 7], fast_link_speed[p]);
            assign unlim  = dec[17];
            assign pend   = q_pend[4*p +: 4];
            // Lower queues run free when queue 3 is not being limited
            assign lo_ok  = unlim | (lo_budget_r != {RATIO_W{1'b0}});
            // One idle cycle after each grant lets the requester retire
            assign idle   = (tx_grant[4*p +: 4] == 4'h0);

            // The shaper is debited by the grant decision itself, one cycle
            // before the grant shows, so a second frame cannot slip through
            // on credit that is already spent.
            egq_port_shaper u_shaper (
                .clk       (clk),
                .rst       (rst),
                .rate_kbps (dec[16:0]),
                .unlimited (unlim),
                .tick      (tick_r),
                .frame_len (q3_len[11*p +: 11]),
                .debit     (grant_nxt[3]),
                .send_ok   (q3_ok)
            );

            // Strict priority, higher queue number wins.
            // Queue 3 is gated only by its own credit; the lower queues share
            // one budget, so a blocked queue 2 also holds back queues 1 and 0.
            // That keeps the ratio pacing simple at the cost of fairness.
            always @* begin
                grant_nxt = 4'h0;
                if (idle) begin
                    if (four_queue_mode[p]) begin
                        if (pend[3] && q3_ok)
                            grant_nxt = 4'h8;
                        else if (pend[2] && lo_ok)
                            grant_nxt = 4'h4;
                        else if (pend[1] && lo_ok)
                            grant_nxt = 4'h2;
                        else if (pend[0] && lo_ok)
                            grant_nxt = 4'h1;
                    end else begin
                        // Two-queue mode: queue 1 high, queue 0 low
                        if (pend[1])
                            grant_nxt = 4'h2;
                        else if (pend[0])
                            grant_nxt = 4'h1;
                    end
                end
            end

            // Gathered into one vector; a single process registers the grants
            assign grant_all[4*p +: 4] = grant_nxt;

            // Lower queues earn ratio frames per queue 3 frame sent.
            // The budget is reloaded, not added to, so idle time on the lower queues
            // cannot bank a long run of lower-queue frames.
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    lo_budget_r <= {RATIO_W{1'b0}};
                end else if (grant_nxt[3]) begin
                    lo_budget_r <= lo_ratio[RATIO_W*p +: RATIO_W];
                end else if (!unlim && four_queue_mode[p] && (grant_nxt[2:0] != 3'h0)) begin
                    lo_budget_r <= lo_budget_r - {{(RATIO_W-1){1'b0}}, 1'b1};
                end
            end
        end
    endgenerate

    // Grants come straight from flip-flops: one owner for the whole vector
    always @(posedge clk or posedge rst) begin
        if (rst)
            tx_grant <= {(4*NPORT){1'b0}};
        else
            tx_grant <= grant_all;
    end

endmodule

// ==== egq_checker.sv ====
/* Port checker for the queue 3 egress rate limiter.
   Assumes the bind below; it sees the design's ports only. */
`timescale 1ns/1ps
`include "egq_consts.vh"
module egq_checker #(parameter NPORT = 5, parameter RATIO_W = 8) (
    // Clock and reset
    input                     clk,
    input                     rst,
    // Register port
    input [7:0]               reg_addr,
    input                     reg_wr,
    input [7:0]               reg_wdata,
    input                     reg_rd,
    input [7:0]               reg_rdata,
    // Queue side
    input [NPORT-1:0]         fast_link_speed,
    input [NPORT-1:0]         four_queue_mode,
    input [4*NPORT-1:0]       q_pend,
    input [11*NPORT-1:0]      q3_len,
    input [RATIO_W*NPORT-1:0] lo_ratio,
    input [4*NPORT-1:0]       tx_grant
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Only port 1 lanes are watched, since every port shares one grant scheme
    wire hit = reg_addr[3:0] == 4'hE && reg_addr[7:4] >= 4'hB;
    sequence s_wr; reg_wr && reg_addr == `EGQ_Q3_RATE_P1_OFF; endsequence
    sequence s_rd; reg_rd && !reg_wr && reg_addr == `EGQ_Q3_RATE_P1_OFF; endsequence
    a_code_read_back: assert property (s_wr ##1 s_rd |=>
        reg_rdata == ($past(reg_wdata, 2) & 8'h7F)) else $error("bad read back");
    a_unmapped_reads_zero: assert property (reg_rd && !hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_top_bit_zero: assert property (reg_rd |=> !reg_rdata[7])
        else $error("bit 7 set");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_grant_one_hot: assert property ($onehot0(tx_grant[3:0]))
        else $error("grant not one-hot");
    a_grant_gap: assert property (|tx_grant[3:0] |=> tx_grant[3:0] == 4'h0)
        else $error("grant not followed by idle");
    a_grant_needs_pend: assert property (tx_grant[3] |-> $past(q_pend[3]))
        else $error("grant without request");
    a_two_queue_only: assert property (!$past(four_queue_mode[0]) |-> tx_grant[3:2] == 2'h0)
        else $error("upper queue granted in two-queue mode");
    a_q0_after_q1: assert property (tx_grant[0] |-> !$past(q_pend[1]))
        else $error("queue 0 passed queue 1");
    a_q1_after_q2: assert property (
        tx_grant[1] && $past(four_queue_mode[0]) |-> !$past(q_pend[2]))
        else $error("queue 1 passed queue 2");
endmodule
bind egq_rate_limiter egq_checker #(.NPORT(NPORT), .RATIO_W(RATIO_W)) chk (.clk(clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fast_link_speed(fast_link_speed),
    .four_queue_mode(four_queue_mode), .q_pend(q_pend), .q3_len(q3_len),
    .lo_ratio(lo_ratio), .tx_grant(tx_grant));

// ==== testbench.sv ====
/* Bench for the queue 3 egress rate limiter: registers, grant order, rates.
   Assumes the checker file is compiled alongside and binds itself. */
`timescale 1ns/1ps
`include "egq_consts.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %0d got %0d", nm, e, g); end end
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [4:0]  fast_link_speed = 5'h1F;
    logic [4:0]  four_queue_mode = 5'h1F;
    logic [39:0] lo_ratio = {5{8'h02}};
    logic [19:0] q_pend = 20'h00000;
    logic [54:0] q3_len = 55'h0;
    wire  [7:0]  reg_rdata;
    wire  [19:0] tx_grant;
    int          n_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    egq_rate_limiter uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fast_link_speed(fast_link_speed), .four_queue_mode(four_queue_mode),
        .q_pend(q_pend), .q3_len(q3_len), .lo_ratio(lo_ratio), .tx_grant(tx_grant));
    // Core clock and a ceiling on the run length
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("mismatches %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic [7:0] ra(input int p);
        return `EGQ_Q3_RATE_P1_OFF + `EGQ_PORT_STRIDE * 8'(p);
    endfunction
    // Register accesses; read data is registered, so it is taken one edge later
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        `CHK("rdata", e, reg_rdata)
    endtask
    // Hold requests on port 1 and log the grant order, one digit per grant
    task automatic serve(input logic [3:0] m, input logic [15:0] e);
        logic [15:0] o;
        o = 16'h0000;
        @(posedge clk);
        q_pend[3:0] <= m;
        repeat (20) begin
            @(posedge clk);
            for (int i = 0; i < 4; i++)
                if (tx_grant[i] === 1'b1) begin
                    o = {o[11:0], 4'(i + 1)};
                    q_pend[i] <= 1'b0;
                end
        end
        q_pend[3:0] <= 4'h0;
        `CHK("grant order", e, o)
    endtask
    // One queue 3 frame; g counts cycles from request to grant
    task automatic frame(input int p, output int g);
        q_pend[4*p+3] <= 1'b1;
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while (tx_grant[4*p+3] !== 1'b1 && g < 40000);
        q_pend[4*p+3] <= 1'b0;
        @(posedge clk);
    endtask
    // Drain first: an unlimited spell leaves the bucket full and hides the rate
    task automatic run(input int p, input bit f, input int c, input int len);
        int g, k, n, r;
        bit lim, ok;
        lim = (c >= 101 && c <= 115) || (c >= 1 && c <= (f ? 99 : 9));
        r = c <= 99 ? c * 1000 : (c - 100) * 64;
        n = lim ? (len * 8000 + r - 1) / r : 0;
        fast_link_speed[p] <= f;
        q3_len[11*p +: 11] <= len[10:0];
        wr(ra(p), 8'(c));
        chk_rd(ra(p), 8'(c));
        for (k = 0; k < (lim ? 2100 : 30); k++) begin
            frame(p, g);
            if (g > 2)
                break;
        end
        frame(p, g);
        ok = lim ? (g > (n - 2) * 200 && g <= n * 200 + 4) : (g == 2);
        `CHK("q3 gap", 1'b1, ok)
    endtask
    initial begin
        int k;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (k = 0; k < 5; k++)
            chk_rd(ra(k), 8'h00);
        wr(8'hBD, 8'h55);
        chk_rd(8'hBD, 8'h00);
        wr(ra(0), 8'hFF);
        chk_rd(ra(0), 8'h7F);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        chk_rd(ra(0), 8'h00);
        serve(4'hF, 16'h4321);
        four_queue_mode[0] <= 1'b0;
        serve(4'hF, 16'h0021);
        four_queue_mode[0] <= 1'b1;
        run(0, 1, 1, 1);
        // Limited queue 3: lower queues get the ratio budget and no more
        for (int rt = 2; rt <= 3; rt++) begin
            lo_ratio[7:0] <= 8'(rt);
            frame(0, k);
            q_pend[0] <= 1'b1;
            k = 0;
            repeat (100) begin
                @(posedge clk);
                k += tx_grant[0] === 1'b1;
            end
            q_pend[0] <= 1'b0;
            `CHK("low grants", rt, k)
        end
        run(1, 1, 50, 64);
        run(2, 1, 99, 64);
        run(3, 1, 115, 1);
        run(4, 0, 9, 8);
        run(0, 0, 113, 1);
        run(1, 1, 0, 64);
        run(2, 1, 100, 64);
        run(3, 1, 116, 64);
        run(4, 0, 10, 64);
        run(0, 0, 50, 64);
        run(1, 0, 127, 64);
        complete_run();
    end
endmodule
